// ### hw/scrs_fifo.sv
/*
  First-in first-out buffer for host bytes waiting to go to the card.
  Assumes DEPTH is a power of two; both sides share clk.
*/
`timescale 1ns/1ps
module scrs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill and drain sides
  scrs_stream_if.sink wr,
  scrs_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rp_q[AW-1:0]];
  assign push = wr.valid && !full;
  assign pop = rd.ready && !empty;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

// ### hw/scrs_top.sv
/*
  Contact smart card reader sequencer: card power and activation states,
  answer-to-reset protocol decode, and T=0 byte transfer with parity
  refusal and repetition on the half-duplex I/O contact.
  Assumes an external pull-up on the I/O contact and a card using the
  direct convention; the I/O contact is driven open-drain.
*/
`timescale 1ns/1ps
module scrs_top #(
  parameter int unsigned ATR_WAIT_CLKS = scrs_pkg::ATR_WAIT_CLKS_DEF,
  // Bit time in card clocks; a bench may shorten it to keep a run brief.
  parameter int unsigned ETU_CLKS = scrs_pkg::ETU_CARD_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host control and report
  input wire logic host_start,
  input wire logic host_off,
  output logic [2:0] card_state_report,
  output logic [3:0] card_protocol,
  output logic atr_fail,
  output logic [15:0] card_status_word,
  // Host bytes towards the card
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Card bytes towards the host
  output logic [7:0] rx_data,
  output logic rx_valid,
  // Card contacts
  output logic card_vcc_on,
  output logic card_if_en,
  output logic card_clk,
  output logic card_rst_pin,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe
);
  localparam logic [15:0] ATR_WAIT_LAST = 16'(ATR_WAIT_CLKS - 1);
  localparam logic [11:0] ETU_LAST = 12'(ETU_CLKS * scrs_pkg::CARD_CLK_DIV - 1);
  localparam logic [11:0] ETU_RX_START = 12'(ETU_CLKS * scrs_pkg::CARD_CLK_DIV / 2);

  scrs_pkg::scrs_state_t state_q;
  scrs_pkg::scrs_state_t state_d;
  logic [2:0] io_sync_q;
  logic io_lvl_q;
  logic io_prev_q;
  logic [2:0] div_q;
  logic clk_q;
  logic clk_rise;
  logic clk_run;
  logic if_en;
  logic in_reset;
  logic [15:0] wait_q;
  logic wait_done;
  logic fail_q;
  // Answer decode.
  logic [1:0] atr_phase_q;
  logic [2:0] atr_left_q;
  logic atr_td_q;
  logic atr_done;
  logic [3:0] proto_new;
  logic [3:0] proto_q;
  // Receiver.
  logic rx_busy_q;
  logic [3:0] rx_idx_q;
  logic [11:0] rx_cnt_q;
  logic [7:0] rx_shift_q;
  logic rx_echo_q;
  logic rx_bad_q;
  logic rx_low_q;
  logic nak_q;
  logic rx_tick;
  logic rx_start;
  logic rx_end;
  logic rx_byte_ok;
  logic frame_err;
  logic [7:0] rx_data_q;
  logic rx_valid_q;
  logic [15:0] status_q;
  // Transmitter.
  logic tx_busy_q;
  logic [3:0] tx_idx_q;
  logic [11:0] tx_cnt_q;
  logic [7:0] tx_byte_q;
  logic tx_arm_q;
  logic tx_resend_q;
  logic tx_tick;
  logic tx_take;
  logic tx_bit;
  logic oe_q;

  scrs_stream_if #(.W(scrs_pkg::BYTE_W)) fill_if ();
  scrs_stream_if #(.W(scrs_pkg::BYTE_W)) drain_if ();

  assign fill_if.data = tx_data;
  assign fill_if.valid = tx_valid;
  assign tx_ready = fill_if.ready;

  scrs_fifo #(
    .W(scrs_pkg::BYTE_W),
    .DEPTH(scrs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .wr(fill_if.sink),
    .rd(drain_if.source)
  );

  // Card state and contact levels.
  assign if_en = (state_q != scrs_pkg::CARD_UNPOWERED_STATE);
  assign clk_run = if_en && (state_q != scrs_pkg::INTERFACE_INITIALISED_STATE);
  assign in_reset = (state_q == scrs_pkg::RESET_ASSERTED_STATE) ||
                    (state_q == scrs_pkg::RESET_RELEASED_STATE);
  assign card_state_report = state_q;
  assign card_if_en = if_en;
  assign card_vcc_on = clk_run;
  // The divider flop may still be high in the first cycle after power-off.
  assign card_clk = clk_q && clk_run;
  assign card_rst_pin = clk_run && (state_q != scrs_pkg::RESET_ASSERTED_STATE);
  assign card_protocol = proto_q;
  assign atr_fail = fail_q;
  assign card_status_word = status_q;
  assign rx_data = rx_data_q;
  assign rx_valid = rx_valid_q;
  assign card_io_out = 1'b0;
  assign card_io_oe = oe_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      scrs_pkg::CARD_UNPOWERED_STATE: begin
        if (host_start) begin
          state_d = scrs_pkg::INTERFACE_INITIALISED_STATE;
        end
      end
      scrs_pkg::INTERFACE_INITIALISED_STATE: begin
        state_d = scrs_pkg::RESET_ASSERTED_STATE;
      end
      scrs_pkg::RESET_ASSERTED_STATE: begin
        if (rx_byte_ok) begin
          state_d = scrs_pkg::ATR_RECEIVED_STATE;
        end else if (wait_done) begin
          state_d = scrs_pkg::RESET_RELEASED_STATE;
        end
      end
      scrs_pkg::RESET_RELEASED_STATE: begin
        if (rx_byte_ok) begin
          state_d = scrs_pkg::ATR_RECEIVED_STATE;
        end else if (wait_done) begin
          state_d = scrs_pkg::CARD_UNPOWERED_STATE;
        end
      end
      scrs_pkg::ATR_RECEIVED_STATE: begin
        if (atr_done && (proto_new == scrs_pkg::PROTO_T0)) begin
          state_d = scrs_pkg::PROTOCOL_READY_STATE;
        end
      end
      scrs_pkg::PROTOCOL_READY_STATE: begin
        state_d = scrs_pkg::PROTOCOL_READY_STATE;
      end
      default: begin
        state_d = scrs_pkg::CARD_UNPOWERED_STATE;
      end
    endcase
    if (host_off) begin
      state_d = scrs_pkg::CARD_UNPOWERED_STATE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= scrs_pkg::CARD_UNPOWERED_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // A failed activation stays visible until the host starts again.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fail_q <= 1'b0;
    end else if (state_q == scrs_pkg::RESET_RELEASED_STATE && wait_done && !rx_byte_ok) begin
      fail_q <= 1'b1;
    end else if (host_start) begin
      fail_q <= 1'b0;
    end
  end

  // Card clock divider; it stops low whenever the card is not powered.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 3'h0;
      clk_q <= 1'b0;
    end else if (!clk_run) begin
      div_q <= 3'h0;
      clk_q <= 1'b0;
    end else begin
      div_q <= (div_q == scrs_pkg::DIV_LAST) ? 3'h0 : div_q + 3'h1;
      if (div_q == scrs_pkg::DIV_HALF || div_q == scrs_pkg::DIV_LAST) begin
        clk_q <= !clk_q;
      end
    end
  end
  assign clk_rise = clk_run && (div_q == scrs_pkg::DIV_LAST);

  // Answer wait, counted in card clocks and restarted by every state change.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 16'h0000;
    end else if (state_d != state_q || !in_reset) begin
      wait_q <= 16'h0000;
    end else if (clk_rise) begin
      wait_q <= wait_q + 16'h0001;
    end
  end
  assign wait_done = in_reset && clk_rise && (wait_q == ATR_WAIT_LAST);

  // Contact synchroniser; a level counts once the last two stages agree.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_sync_q <= 3'b111;
      io_lvl_q <= 1'b1;
      io_prev_q <= 1'b1;
    end else begin
      io_sync_q <= {io_sync_q[1:0], card_io_in};
      if (io_sync_q[1] == io_sync_q[2]) begin
        io_lvl_q <= io_sync_q[2];
      end
      io_prev_q <= io_lvl_q;
    end
  end

  // Receiver samples mid-bit; it also runs while sending to catch the echo.
  assign rx_start = if_en && !rx_busy_q && io_prev_q && !io_lvl_q;
  assign rx_tick = rx_busy_q && (rx_cnt_q == ETU_LAST);
  assign rx_end = rx_tick && (rx_idx_q == scrs_pkg::IDX_NAK);
  assign rx_byte_ok = rx_end && !rx_echo_q && !rx_bad_q;
  assign frame_err = rx_end && rx_echo_q && (rx_low_q || !io_lvl_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_busy_q <= 1'b0;
      rx_idx_q <= scrs_pkg::IDX_START;
      rx_cnt_q <= 12'h000;
      rx_shift_q <= scrs_pkg::BYTE_RST;
      rx_echo_q <= 1'b0;
      rx_bad_q <= 1'b0;
      rx_low_q <= 1'b0;
      nak_q <= 1'b0;
    end else if (!if_en) begin
      rx_busy_q <= 1'b0;
      nak_q <= 1'b0;
    end else if (rx_start) begin
      rx_busy_q <= 1'b1;
      rx_idx_q <= scrs_pkg::IDX_START;
      rx_cnt_q <= ETU_RX_START;
      rx_echo_q <= tx_busy_q;
      rx_bad_q <= 1'b0;
      rx_low_q <= 1'b0;
    end else if (rx_busy_q) begin
      rx_cnt_q <= rx_tick ? 12'h000 : rx_cnt_q + 12'h001;
      if (rx_idx_q == scrs_pkg::IDX_NAK && !io_lvl_q) begin
        rx_low_q <= 1'b1;
      end
      if (rx_tick) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == scrs_pkg::IDX_START && io_lvl_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_idx_q < scrs_pkg::IDX_PAR) begin
          rx_shift_q <= {io_lvl_q, rx_shift_q[7:1]};
        end else if (rx_idx_q == scrs_pkg::IDX_PAR) begin
          rx_bad_q <= scrs_pkg::scrs_par8(rx_shift_q) ^ io_lvl_q;
        end else if (rx_idx_q == scrs_pkg::IDX_STOP) begin
          rx_low_q <= !io_lvl_q;
          nak_q <= !rx_echo_q && rx_bad_q;
        end else begin
          rx_busy_q <= 1'b0;
          nak_q <= 1'b0;
        end
      end
    end
  end

  // Good card bytes go to the host; the last two taken in the ready state form the status word.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_q <= scrs_pkg::BYTE_RST;
      rx_valid_q <= 1'b0;
      status_q <= scrs_pkg::STATUS_RST;
    end else begin
      rx_valid_q <= rx_byte_ok;
      if (rx_byte_ok) begin
        rx_data_q <= rx_shift_q;
      end
      if (rx_byte_ok && state_q == scrs_pkg::PROTOCOL_READY_STATE) begin
        status_q <= {status_q[7:0], rx_shift_q};
      end
    end
  end

  // Answer decode: format byte, then interface bytes up to the first TD.
  assign proto_new = (atr_phase_q == 2'd1 && atr_td_q) ? rx_shift_q[3:0] : scrs_pkg::PROTO_T0;
  assign atr_done = rx_byte_ok && (state_q == scrs_pkg::ATR_RECEIVED_STATE) &&
                    ((atr_phase_q == 2'd0 && scrs_pkg::scrs_ifcount(rx_shift_q[7:4]) == 3'h0) ||
                     (atr_phase_q == 2'd1 && atr_left_q == 3'h1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      atr_phase_q <= 2'd0;
      atr_left_q <= 3'h0;
      atr_td_q <= 1'b0;
      proto_q <= scrs_pkg::PROTO_T0;
    end else if (state_q != scrs_pkg::ATR_RECEIVED_STATE) begin
      if (in_reset) begin
        atr_phase_q <= 2'd0;
      end
    end else if (atr_done) begin
      atr_phase_q <= 2'd2;
      proto_q <= proto_new;
    end else if (rx_byte_ok && atr_phase_q == 2'd0) begin
      atr_phase_q <= 2'd1;
      atr_left_q <= scrs_pkg::scrs_ifcount(rx_shift_q[7:4]);
      atr_td_q <= rx_shift_q[7];
    end else if (rx_byte_ok && atr_phase_q == 2'd1) begin
      atr_left_q <= atr_left_q - 3'h1;
    end
  end

  // Transmitter; a refused byte is repeated once the guard time has passed.
  assign drain_if.ready = (state_q == scrs_pkg::PROTOCOL_READY_STATE) &&
                          !tx_busy_q && !rx_busy_q;
  assign tx_take = drain_if.ready && drain_if.valid;
  assign tx_tick = tx_busy_q && (tx_cnt_q == ETU_LAST);

  always_comb begin
    tx_bit = 1'b1;
    if (tx_idx_q == scrs_pkg::IDX_START) begin
      tx_bit = 1'b0;
    end else if (tx_idx_q < scrs_pkg::IDX_PAR) begin
      tx_bit = tx_byte_q[3'(tx_idx_q - 4'h1)];
    end else if (tx_idx_q == scrs_pkg::IDX_PAR) begin
      tx_bit = scrs_pkg::scrs_par8(tx_byte_q);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_busy_q <= 1'b0;
      tx_idx_q <= scrs_pkg::IDX_START;
      tx_cnt_q <= 12'h000;
      tx_byte_q <= scrs_pkg::BYTE_RST;
    end else if (state_q != scrs_pkg::PROTOCOL_READY_STATE) begin
      tx_busy_q <= 1'b0;
    end else if (tx_take) begin
      tx_busy_q <= 1'b1;
      tx_idx_q <= scrs_pkg::IDX_START;
      tx_cnt_q <= 12'h000;
      tx_byte_q <= drain_if.data;
    end else if (tx_busy_q) begin
      tx_cnt_q <= tx_tick ? 12'h000 : tx_cnt_q + 12'h001;
      if (tx_tick) begin
        if (tx_idx_q != scrs_pkg::IDX_TX_END) begin
          tx_idx_q <= tx_idx_q + 4'h1;
        end else if (tx_resend_q) begin
          tx_idx_q <= scrs_pkg::IDX_START;
        end else begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // Frame error source: armed per byte sent, disarmed when it fires.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_arm_q <= 1'b0;
      tx_resend_q <= 1'b0;
    end else begin
      if (frame_err && tx_arm_q) begin
        tx_arm_q <= 1'b0;
      end else if (tx_take || (tx_tick && tx_idx_q == scrs_pkg::IDX_TX_END)) begin
        tx_arm_q <= 1'b1;
      end
      if (frame_err && tx_arm_q) begin
        tx_resend_q <= 1'b1;
      end else if (tx_tick && tx_idx_q == scrs_pkg::IDX_TX_END) begin
        tx_resend_q <= 1'b0;
      end
    end
  end

  // Open-drain drive: only zeros are driven, ones come from the pull-up.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= if_en && ((tx_busy_q && !tx_bit) || nak_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_nak_start;
    rx_tick && rx_idx_q == scrs_pkg::IDX_STOP && !rx_echo_q && rx_bad_q;
  endsequence
  sequence s_resend_trigger;
    frame_err && tx_arm_q;
  endsequence

  a_unpowered_quiet: assert property (
    state_q == scrs_pkg::CARD_UNPOWERED_STATE |-> !card_vcc_on && !card_if_en && !card_clk)
    else $error("card not quiet while unpowered");
  a_init_no_power: assert property (
    state_q == scrs_pkg::INTERFACE_INITIALISED_STATE |-> card_if_en && !card_vcc_on && !card_clk)
    else $error("initialised state drives power or clock");
  a_reset_low_drive: assert property (
    state_q == scrs_pkg::RESET_ASSERTED_STATE |-> !card_rst_pin && card_vcc_on ##[1:5]
    (card_clk != $past(card_clk) || state_q != scrs_pkg::RESET_ASSERTED_STATE))
    else $error("reset asserted state wrong on contacts");
  a_timeout_release: assert property (
    state_q == scrs_pkg::RESET_ASSERTED_STATE && wait_done && !rx_byte_ok && !host_off
    |=> state_q == scrs_pkg::RESET_RELEASED_STATE && card_rst_pin)
    else $error("missing reset release after answer timeout");
  a_wait_bound: assert property (
    in_reset && !rx_byte_ok |-> wait_q <= ATR_WAIT_LAST)
    else $error("answer wait exceeded its bound");
  a_atr_enter: assert property (
    in_reset && rx_byte_ok && !host_off |=> state_q == scrs_pkg::ATR_RECEIVED_STATE)
    else $error("answer byte did not start decode");
  a_t0_ready: assert property (
    state_q == scrs_pkg::ATR_RECEIVED_STATE && atr_done && proto_new == scrs_pkg::PROTO_T0
    && !host_off |=> state_q == scrs_pkg::PROTOCOL_READY_STATE && card_protocol == 4'h0)
    else $error("T0 answer did not reach ready state");
  a_cmd_only_ready: assert property (
    drain_if.ready |-> state_q == scrs_pkg::PROTOCOL_READY_STATE)
    else $error("command byte taken outside ready state");
  a_off_request: assert property (
    host_off |=> state_q == scrs_pkg::CARD_UNPOWERED_STATE ##1 !card_vcc_on)
    else $error("power off request ignored");
  a_parity_nak: assert property (
    s_nak_start |=> nak_q ##1 card_io_oe)
    else $error("parity error not signalled on the line");
  a_parity_pass: assert property (
    rx_end && !rx_echo_q && !rx_bad_q |=> rx_valid && rx_data == $past(rx_shift_q))
    else $error("good card byte not delivered");
  a_resend_same: assert property (
    s_resend_trigger |=> tx_resend_q && !tx_arm_q && tx_byte_q == $past(tx_byte_q))
    else $error("frame error did not arm a repeat");
  a_echo_capture: assert property (
    tx_take |-> ##[1:8] (rx_busy_q && rx_echo_q) || !tx_busy_q)
    else $error("own byte not captured by the receiver");
  a_status_shift: assert property (
    rx_byte_ok && state_q == scrs_pkg::PROTOCOL_READY_STATE
    |=> card_status_word[7:0] == $past(rx_shift_q))
    else $error("status word not updated");
endmodule

// ### include/scrs_pkg.sv
/*
  Constants, state codes and helper functions shared by the contact smart card
  reader sequencer and its transmit buffer.
  Assumes a 50 MHz system clock and a card that uses the direct convention.
*/
// Function
// - Unpowered: no supply, interface off, no clock.
// - Initialised: interface on, no supply, no clock.
// - Reset asserted: RST low, supply and clock on.
// - No answer: raise RST, wait again.
// - Answer arrives: decode it, report the protocol.
// - T0 found: ready state, commands only there.
// - Report state; host request powers card off.
// - Receiver checks even parity of every byte.
// - Parity error: receiver holds line low.
// - Transmitter resends byte the receiver refused.
// - Reader pulls line low in stop bits.
// - Reader echoes own byte, flags low stop.
// - On frame error resend, disarm error source.
// - Return card status word with card state.
package scrs_pkg;
  localparam int unsigned SYS_CLK_PERIOD_NS = 20;
  localparam int unsigned CARD_CLK_PERIOD_NS = 160;
  localparam int unsigned CARD_CLK_DIV = CARD_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [2:0] DIV_LAST = 3'(CARD_CLK_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(CARD_CLK_DIV / 2 - 1);
  localparam int unsigned ETU_CARD_CLKS = 372;
  localparam int unsigned ETU_CYC = ETU_CARD_CLKS * CARD_CLK_DIV;
  localparam logic [11:0] ETU_LAST = 12'(ETU_CYC - 1);
  localparam logic [11:0] ETU_RX_START = 12'(ETU_CYC / 2);
  localparam int unsigned ATR_WAIT_CLKS_DEF = 40000;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned STATUS_W = 16;
  localparam int unsigned FILE_ID_W = 16;
  localparam int unsigned OFFSET_W = 16;
  localparam int unsigned PIN_BYTES = 8;
  localparam int unsigned PIN_COUNT = 4;
  localparam logic [3:0] PROTO_T0 = 4'h0;
  localparam logic [3:0] IDX_START = 4'h0;
  localparam logic [3:0] IDX_PAR = 4'h9;
  localparam logic [3:0] IDX_STOP = 4'ha;
  localparam logic [3:0] IDX_NAK = 4'hb;
  localparam logic [3:0] IDX_TX_END = 4'hd;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  typedef enum logic [2:0] {
    CARD_UNPOWERED_STATE = 3'b000,
    INTERFACE_INITIALISED_STATE = 3'b001,
    RESET_ASSERTED_STATE = 3'b010,
    RESET_RELEASED_STATE = 3'b011,
    ATR_RECEIVED_STATE = 3'b100,
    PROTOCOL_READY_STATE = 3'b101
  } scrs_state_t;

  // Even parity: data bits and parity bit together hold an even number of ones.
  function automatic logic scrs_par8(input logic [7:0] d);
    return ^d;
  endfunction

  // Number of interface bytes announced by the high nibble of a format byte.
  function automatic logic [2:0] scrs_ifcount(input logic [3:0] y);
    return 3'(y[0]) + 3'(y[1]) + 3'(y[2]) + 3'(y[3]);
  endfunction
endpackage

// ### include/scrs_stream_if.sv
/*
  Byte stream with valid and ready, used between the sequencer and its buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface scrs_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport source (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface

// ### sim/scrs_card_model.sv
/*
  Behavioural contact card on the half-duplex I/O contact.
  Assumes the bench resolves the wire with a pull-up; io_pull high pulls it low.
*/
`timescale 1ns/1ps
module scrs_card_model #(
  parameter int ETU_NS = 59520
) (
  // Contact
  input wire logic io_wire,
  output logic io_pull
);
  logic sending = 1'b0;
  logic nak_next = 1'b0;
  logic [7:0] rx_last = 8'h00;
  logic [15:0] rx_pair = 16'h0000;
  int rx_cnt = 0;
  int nak_seen = 0;

  initial io_pull = 1'b0;

  // A corrupted first attempt models a line hit; repeats go out clean.
  task automatic send_byte(input logic [7:0] d, input logic corrupt);
    logic [8:0] fr;
    logic again;
    sending = 1'b1;
    again = 1'b1;
    while (again) begin
      fr = {(^d) ^ corrupt, d};
      io_pull = 1'b1;
      #(ETU_NS);
      for (int i = 0; i < 9; i++) begin
        io_pull = !fr[i];
        #(ETU_NS);
      end
      io_pull = 1'b0;
      #(ETU_NS);
      again = !io_wire;
      nak_seen += int'(again);
      corrupt = 1'b0;
      #(ETU_NS * 2);
    end
    sending = 1'b0;
  endtask

  task automatic rx_frame();
    logic [8:0] b;
    #(ETU_NS * 3 / 2);
    for (int i = 0; i < 9; i++) begin
      b[i] = io_wire;
      #(ETU_NS);
    end
    if (nak_next || ^b) begin
      io_pull = 1'b1;
      nak_next = 1'b0;
    end
    #(ETU_NS);
    io_pull = 1'b0;
    rx_last = b[7:0];
    rx_pair = {rx_pair[7:0], b[7:0]};
    rx_cnt++;
  endtask

  always @(negedge io_wire) begin
    if (!sending) begin
      rx_frame();
    end
  end
endmodule

// ### sim/scrs_top_tb.sv
/*
  Self-checking bench for the card reader sequencer.
  Assumes the card model above; a second reader with a short answer wait
  exercises the timeout path without a card.
*/
`timescale 1ns/1ps
module scrs_top_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic host_start = 1'b0;
  logic host_off = 1'b0;
  logic s2_start = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic [2:0] st, st2;
  logic [3:0] proto;
  logic [15:0] status;
  logic tx_ready, rx_valid, vcc, en, cclk, rst_pin, io_out, io_oe, card_pull, io_wire;
  logic [7:0] rx_data;
  logic s2_vcc, s2_en, s2_clk, s2_rst, s2_fail;
  int error_cnt = 0;
  int n_checks = 0;
  int rx_pulses = 0;
  localparam logic [15:0] FILE_ID = 16'h1e07;
  localparam logic [15:0] OFFSET = 16'h0104;
  localparam logic [7:0] PIN_SEL = 8'h03;

  always #10 clk = !clk;
  assign io_wire = (io_oe ? io_out : 1'b1) & !card_pull;
  always @(posedge clk) rx_pulses += int'(rx_valid === 1'b1);

  // A short bit time keeps the run brief; the answer wait spans 13 bit times.
  scrs_top #(.ATR_WAIT_CLKS(416), .ETU_CLKS(32)) scrs_top_i (.clk(clk), .resetn(resetn),
    .host_start(host_start), .host_off(host_off), .card_state_report(st),
    .card_protocol(proto), .atr_fail(), .card_status_word(status), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .card_vcc_on(vcc), .card_if_en(en), .card_clk(cclk), .card_rst_pin(rst_pin),
    .card_io_in(io_wire), .card_io_out(io_out), .card_io_oe(io_oe));
  scrs_top #(.ATR_WAIT_CLKS(20), .ETU_CLKS(32)) scrs_top_i2 (.clk(clk), .resetn(resetn),
    .host_start(s2_start), .host_off(host_off), .card_state_report(st2),
    .card_protocol(), .atr_fail(s2_fail), .card_status_word(), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(), .rx_data(), .rx_valid(), .card_vcc_on(s2_vcc),
    .card_if_en(s2_en), .card_clk(s2_clk), .card_rst_pin(s2_rst), .card_io_in(1'b1),
    .card_io_out(), .card_io_oe());
  scrs_card_model #(.ETU_NS(5120)) card_i (.io_wire(io_wire), .io_pull(card_pull));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_st(input logic two, input logic [2:0] s, input int lim, output int n);
    n = 0;
    while ((two ? st2 : st) !== s && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if ((two ? st2 : st) !== s) begin
      chk(16'(two ? st2 : st), 16'(s));
    end
  endtask

  task automatic push(input logic [7:0] d);
    @(posedge clk);
    #1;
    tx_data = d;
    tx_valid = 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    #1;
    tx_valid = 1'b0;
  endtask

  task automatic card_wait(input int cnt);
    int n;
    n = 0;
    while (card_i.rx_cnt < cnt && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk(16'(card_i.rx_cnt), 16'(cnt));
  endtask

  task automatic pulse(input logic two);
    @(posedge clk);
    #1;
    if (two) s2_start = 1'b1;
    else host_start = 1'b1;
    @(posedge clk);
    #1;
    s2_start = 1'b0;
    host_start = 1'b0;
  endtask

  task automatic t_timeout();
    int n;
    logic c;
    chk(16'({s2_vcc, s2_en, s2_clk, st2}), 16'h0000);
    pulse(1'b1);
    chk(16'({s2_vcc, s2_en, s2_clk, st2}), 16'h0011);
    @(posedge clk);
    #1;
    chk(16'({s2_vcc, s2_rst, st2}), 16'h0012);
    repeat (8) @(posedge clk);
    #1;
    c = s2_clk;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(c != s2_clk), 16'h0001);
    wait_st(1'b1, 3'h3, 400, n);
    chk(16'(n >= 140 && n <= 175), 16'h0001);
    chk(16'({s2_rst, st2}), 16'h000b);
    wait_st(1'b1, 3'h0, 400, n);
    chk(16'({s2_fail, s2_vcc, st2}), 16'h0010);
  endtask

  task automatic t_atr();
    int n;
    pulse(1'b0);
    wait_st(1'b0, 3'h2, 4, n);
    chk(16'({vcc, rst_pin, st}), 16'h0012);
    card_i.send_byte(8'h3b, 1'b0);
    chk(16'(st), 16'h0004);
    card_i.send_byte(8'h00, 1'b0);
    wait_st(1'b0, 3'h5, 200, n);
    chk(16'({proto, 1'b0, st}), 16'h0005);
  endtask

  task automatic t_rx();
    rx_pulses = 0;
    card_i.send_byte(8'h5a, 1'b1);
    card_i.send_byte(8'hc3, 1'b0);
    chk(16'(card_i.nak_seen), 16'h0001);
    chk(16'(rx_pulses), 16'h0002);
    chk(16'(rx_data), 16'h00c3);
    chk(status, 16'h5ac3);
  endtask

  // The card refuses the first byte; the reader must repeat it exactly once.
  task automatic t_tx();
    card_i.nak_next = 1'b1;
    @(posedge clk);
    #1;
    chk(16'(tx_ready), 16'h0001);
    push(FILE_ID[15:8]);
    push(FILE_ID[7:0]);
    card_wait(3);
    chk(card_i.rx_pair, FILE_ID);
    push(OFFSET[15:8]);
    push(OFFSET[7:0]);
    card_wait(5);
    chk(card_i.rx_pair, OFFSET);
    push(PIN_SEL);
    card_wait(6);
    chk(16'(card_i.rx_last), 16'(PIN_SEL));
    chk(16'(rx_pulses), 16'h0002);
  endtask

  task automatic t_off();
    @(posedge clk);
    #1;
    host_off = 1'b1;
    @(posedge clk);
    #1;
    host_off = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(16'({vcc, en, cclk, st}), 16'h0000);
    chk(16'({s2_vcc, s2_en, s2_clk, st2}), 16'h0000);
  endtask

  task automatic results();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_timeout();
    t_atr();
    t_rx();
    t_tx();
    t_off();
    results();
  end

  // Eleven short card frames take about 40000 cycles, well inside this span.
  initial begin
    #(1200000);
    error_cnt++;
    results();
  end
endmodule
